// ---- design/dbdp_regs.svh ----
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 32-bit avalon slave, word addressed by byte offset
// Notes:   included by bare name
`ifndef DBDP_REGS_SVH
`define DBDP_REGS_SVH

`define DBDP_OFS_CTRL      4'h0
`define DBDP_OFS_CMD       4'h4
`define DBDP_OFS_WDATA     4'h8
`define DBDP_OFS_RDATA     4'hc

`define DBDP_CTRL_RESET    32'h0000_0000
`define DBDP_BIT_WPST_EXT  4
`define DBDP_BIT_ODT_ON    5
`define DBDP_BIT_BL32      6
`define DBDP_BIT_GO        31
`define DBDP_BIT_WRITE     30
`define DBDP_CMD_COL_LSB   0
`define DBDP_CMD_BANK_LSB  10

`define DBDP_STAT_BUSY     0
`define DBDP_STAT_DONE     1

`define DBDP_PREAMBLE_CYC  3'h2
`define DBDP_WR_RECOV_NS   18
`define DBDP_CLK_NS        50
`define DBDP_WR_RECOV_CYC  ((`DBDP_WR_RECOV_NS + `DBDP_CLK_NS - 1) / `DBDP_CLK_NS)
`define DBDP_SKEW_CYC      1
`define DBDP_ODT_ON_LAT    2
`define DBDP_ODT_ON_MIN    1

`endif

// ---- design/dbdp_pkg.sv ----
// Purpose: types shared by the burst data phase controller
// Assumes: nothing beyond dbdp_regs.svh
// Notes:   the package holds types only
package dbdp_pkg;

    typedef enum logic [2:0] {
        DBDP_IDLE = 3'b000,
        DBDP_CMD  = 3'b001,
        DBDP_WAIT = 3'b011,
        DBDP_DATA = 3'b010,
        DBDP_TAIL = 3'b110,
        DBDP_GAP  = 3'b111
    } dbdp_state_t;

    typedef struct packed {
        logic       write;
        logic [2:0] bank;
        logic [9:0] col;
    } dbdp_req_t;

    typedef struct packed {
        logic       dqs;
        logic       dqs_oe;
        logic [7:0] dq;
        logic       dq_oe;
    } dbdp_pins_t;

endpackage : dbdp_pkg

// ---- design/dbdp_sync3.sv ----
// Purpose: three-flop synchroniser with agreement qualifier
// Assumes: one clock domain clk_i
// Notes:   a change counts once the second and third stages agree
`timescale 1ns/10ps
module dbdp_sync3 #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_o  <= '0;
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < W; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    q_o[i] <= s3_r[i];
                end
            end
        end
    end
endmodule : dbdp_sync3

// ---- design/dbdp_clkdiv.sv ----
// Purpose: link clock divider and enable pulses
// Assumes: DIV even and at least 2
// Notes:   rise_o pulses the cycle the link clock goes high
`timescale 1ns/10ps
module dbdp_clkdiv #(
    parameter int DIV = 4
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    output logic      ck_o,
    output logic      rise_o,
    output logic      fall_o
);
    localparam int CW = $clog2(DIV);
    logic [CW-1:0] cnt_r;

    initial begin
        if (DIV < 2 || DIV % 2 != 0) $error("dbdp_clkdiv: DIV must be even, >= 2");
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r  <= '0;
            ck_o   <= 1'b0;
            rise_o <= 1'b0;
            fall_o <= 1'b0;
        end else begin
            rise_o <= 1'b0;
            fall_o <= 1'b0;
            if (cnt_r == CW'(DIV / 2 - 1)) begin
                cnt_r  <= '0;
                ck_o   <= ~ck_o;
                rise_o <= ~ck_o;
                fall_o <= ck_o;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end
endmodule : dbdp_clkdiv

// ---- design/dbdp_host.sv ----
// Purpose: host controller for burst read and write data phase on one channel
// Assumes: link clock made here by divider; device strobe sampled by 3 flops
// Notes:   one dq byte lane, one strobe, strobe toggles once per link cycle half
//
// How it works
// - read columns sent as column bits 9:4, low two bits not zeroed
// - read-to-write gap without termination enforced
// - read-to-write gap with termination enforced
// - every read followed by its read-to-write gap, no seamless reads
// - write preamble exactly two link clocks
// - write postamble half or 1.5 clocks
// - write column bits 5:4 driven low
// - first write strobe edge after write delay
// - write strobe launched ahead of data
// - write beat held full half cycle, last beat driven one system clock
// - strobe keeps toggling through write tail only with extended postamble, held low in the half-clock tail
// - write recovery wait before next command
`timescale 1ns/10ps
`include "dbdp_regs.svh"
module dbdp_host #(
    parameter int DIV      = 4,
    parameter int RD_DELAY = 6,
    parameter int WR_DELAY = 4
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic             ck_o,
    output logic             cs_o,
    output logic [5:0]       ca_o,
    output logic             dqs_o,
    output logic             dqs_oe_o,
    input  wire logic        dqs_i,
    output logic [7:0]       dq_o,
    output logic             dq_oe_o,
    input  wire logic [7:0]  dq_i
);
    initial begin
        if (RD_DELAY < 1 || WR_DELAY < 2 || RD_DELAY > 60 || WR_DELAY > 60)
            $error("dbdp_host: delays out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // link clock and pin synchronisers
    logic ck_w;
    logic rise_w;
    logic fall_w;
    logic dqs_s;
    logic [7:0] dq_s;

    dbdp_clkdiv #(.DIV(DIV)) u_div (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .ck_o   (ck_w),
        .rise_o (rise_w),
        .fall_o (fall_w)
    );

    dbdp_sync3 #(.W(9)) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({dqs_i, dq_i}),
        .q_o   ({dqs_s, dq_s})
    );

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ck_o <= 1'b0;
        end else begin
            ck_o <= ck_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software registers
    logic [31:0]        ctrl_r;
    logic [31:0]        wdata_r;
    logic [31:0]        rdata_r;
    logic               busy_r;
    logic               done_r;
    logic               go_r;
    dbdp_pkg::dbdp_req_t req_r;
    logic               set_done;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_r            <= `DBDP_CTRL_RESET;
            wdata_r           <= '0;
            go_r              <= 1'b0;
            req_r             <= '0;
            avs_readdata_o    <= '0;
            avs_waitrequest_o <= 1'b1;
            done_r            <= 1'b0;
        end else begin
            go_r              <= 1'b0;
            avs_waitrequest_o <= 1'b1;
            if (set_done) begin
                done_r <= 1'b1;
            end
            if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
                avs_waitrequest_o <= 1'b0;
                if (avs_write_i) begin
                    if (avs_address_i == `DBDP_OFS_CTRL) begin
                        ctrl_r <= avs_writedata_i;
                    end else if (avs_address_i == `DBDP_OFS_CMD) begin
                        if (!busy_r && avs_writedata_i[`DBDP_BIT_GO]) begin
                            go_r         <= 1'b1;
                            req_r.write  <= avs_writedata_i[`DBDP_BIT_WRITE];
                            req_r.bank   <= avs_writedata_i[`DBDP_CMD_BANK_LSB +: 3];
                            req_r.col    <= avs_writedata_i[`DBDP_CMD_COL_LSB +: 10];
                            if (!set_done) begin
                                done_r <= 1'b0;
                            end
                        end
                    end else if (avs_address_i == `DBDP_OFS_WDATA) begin
                        wdata_r <= avs_writedata_i;
                    end
                end else begin
                    if (avs_address_i == `DBDP_OFS_CTRL) begin
                        avs_readdata_o <= ctrl_r;
                    end else if (avs_address_i == `DBDP_OFS_CMD) begin
                        avs_readdata_o <= {30'h0, done_r, busy_r};
                    end else if (avs_address_i == `DBDP_OFS_RDATA) begin
                        avs_readdata_o <= rdata_r;
                    end else begin
                        avs_readdata_o <= '0;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // burst sequencer, waits and gaps counted in link clock rising edges, write beats and tail on both edges
    dbdp_pkg::dbdp_state_t st_r;
    logic [6:0]  cnt_r;
    logic [5:0]  beat_r;
    logic [5:0]  half_bl;
    logic [6:0]  tail_h;
    logic [6:0]  gap_r;
    logic [6:0]  rtw_nxt;
    logic        ext_post;
    logic        odt_on;
    logic        dqs_d_r;

    assign ext_post = ctrl_r[`DBDP_BIT_WPST_EXT];
    assign odt_on   = ctrl_r[`DBDP_BIT_ODT_ON];
    assign half_bl  = ctrl_r[`DBDP_BIT_BL32] ? 6'd16 : 6'd8;
    assign tail_h   = ext_post ? 7'd2 : 7'd0;
    assign set_done = (st_r == dbdp_pkg::DBDP_GAP) && rise_w && (cnt_r == 7'h0);

    always_comb begin
        if (odt_on) begin
            rtw_nxt = 7'(RD_DELAY + `DBDP_SKEW_CYC + int'(half_bl) + (ext_post ? 1 : 0)
                      - `DBDP_ODT_ON_LAT - `DBDP_ODT_ON_MIN + 1);
        end else begin
            rtw_nxt = 7'(RD_DELAY + `DBDP_SKEW_CYC + int'(half_bl) - WR_DELAY
                      + int'(`DBDP_PREAMBLE_CYC) + (ext_post ? 1 : 0));
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r     <= dbdp_pkg::DBDP_IDLE;
            cnt_r    <= '0;
            beat_r   <= '0;
            gap_r    <= '0;
            busy_r   <= 1'b0;
            cs_o     <= 1'b0;
            ca_o     <= '0;
            dqs_o    <= 1'b0;
            dqs_oe_o <= 1'b0;
            dq_o     <= '0;
            dq_oe_o  <= 1'b0;
            rdata_r  <= '0;
            dqs_d_r  <= 1'b0;
        end else begin
            dqs_d_r <= dqs_s;
            case (st_r)
                dbdp_pkg::DBDP_IDLE: begin
                    dqs_oe_o <= 1'b0;
                    dq_oe_o  <= 1'b0;
                    if (go_r) begin
                        busy_r <= 1'b1;
                        st_r   <= dbdp_pkg::DBDP_CMD;
                    end
                end
                dbdp_pkg::DBDP_CMD: begin
                    if (rise_w) begin
                        cs_o <= 1'b1;
                        // column bits 3:0 never sent writes force 5:4 low
                        ca_o <= req_r.write ? {req_r.col[9:6], 2'b00}
                                            : req_r.col[9:4];
                        cnt_r <= 7'(req_r.write ? WR_DELAY : RD_DELAY);
                        st_r  <= dbdp_pkg::DBDP_WAIT;
                    end
                end
                dbdp_pkg::DBDP_WAIT: begin
                    // preamble starts two clocks before first latching edge
                    if (req_r.write && fall_w && cnt_r == 7'(`DBDP_PREAMBLE_CYC)) begin
                        dqs_oe_o <= 1'b1;
                        dqs_o    <= 1'b0;
                    end
                    if (rise_w) begin
                        cs_o <= 1'b0;
                        cnt_r <= cnt_r - 1'b1;
                        if (cnt_r == 7'h1) begin
                            beat_r <= '0;
                            st_r   <= dbdp_pkg::DBDP_DATA;
                        end
                    end
                end
                dbdp_pkg::DBDP_DATA: begin
                    if (req_r.write) begin
                        if (rise_w || fall_w) begin
                            dqs_o   <= fall_w;
                            dq_oe_o <= 1'b1;
                            dq_o    <= wdata_r[8*beat_r[1:0] +: 8];
                            beat_r  <= beat_r + 1'b1;
                            if (beat_r == 6'(2 * half_bl - 1)) begin
                                cnt_r <= tail_h;
                                st_r  <= dbdp_pkg::DBDP_TAIL;
                            end
                        end
                    end else if (dqs_s != dqs_d_r) begin
                        if (beat_r < 6'h4) begin
                            rdata_r[8*beat_r[1:0] +: 8] <= dq_s;
                        end
                        beat_r <= beat_r + 1'b1;
                        if (beat_r == 6'(2 * half_bl - 1)) begin
                            cnt_r <= 7'h0;
                            st_r  <= dbdp_pkg::DBDP_TAIL;
                        end
                    end
                end
                dbdp_pkg::DBDP_TAIL: begin
                    dq_oe_o <= 1'b0;
                    if (!req_r.write) begin
                        gap_r <= rtw_nxt;
                        cnt_r <= rtw_nxt;
                        st_r  <= dbdp_pkg::DBDP_GAP;
                    end else if (rise_w || fall_w) begin
                        if (cnt_r == 7'h0) begin
                            dqs_oe_o <= 1'b0;
                            dqs_o    <= 1'b0;
                            cnt_r    <= 7'(`DBDP_WR_RECOV_CYC + 1);
                            st_r     <= dbdp_pkg::DBDP_GAP;
                        end else begin
                            dqs_o <= fall_w;
                            cnt_r <= cnt_r - 1'b1;
                        end
                    end
                end
                dbdp_pkg::DBDP_GAP: begin
                    dqs_oe_o <= 1'b0;
                    if (rise_w) begin
                        if (cnt_r == 7'h0) begin
                            busy_r <= 1'b0;
                            st_r   <= dbdp_pkg::DBDP_IDLE;
                        end else begin
                            cnt_r <= cnt_r - 1'b1;
                        end
                    end
                end
                default: begin
                    st_r <= dbdp_pkg::DBDP_IDLE;
                end
            endcase
        end
    end
endmodule : dbdp_host

// ---- testbench/dbdp_host_asserts.sv ----
// Purpose: port assertions for the burst data phase host
// Assumes: link clock of four system clocks
// Notes:   bound to every dbdp_host instance
`timescale 1ns/10ps
module dbdp_host_asserts (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       avs_read_i,
    input wire logic       avs_write_i,
    input wire logic       avs_waitrequest_o,
    input wire logic       ck_o,
    input wire logic       dqs_oe_o,
    input wire logic [7:0] dq_o,
    input wire logic       dq_oe_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////
    a_ack_one: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("late bus answer");
    a_ack_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("long bus answer");
    a_ack_cause: assert property (!avs_waitrequest_o |-> $past(avs_read_i || avs_write_i))
        else $error("answer without request");
    a_ck_period: assert property (
        $rose(ck_o) |-> ck_o[*2] ##1 !ck_o[*2])
        else $error("link clock period wrong");
    a_pre_len: assert property (
        $rose(dqs_oe_o) |-> !dq_oe_o[*8] ##1 dq_oe_o)
        else $error("write preamble length wrong");
    a_oe_pair: assert property (dq_oe_o |-> dqs_oe_o)
        else $error("data driven without strobe");
    a_beat_hold: assert property (
        dq_oe_o && $changed(dq_o) |=> $stable(dq_o))
        else $error("write beat too short");
    a_wr_tail: assert property ($fell(dq_oe_o) |-> dqs_oe_o ##1
        (!dqs_oe_o or (dqs_oe_o[*4] ##1 !dqs_oe_o)))
        else $error("write postamble missing");
endmodule : dbdp_host_asserts

bind dbdp_host dbdp_host_asserts i_chk (.clk_i(clk_i), .rst_i(rst_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .ck_o(ck_o),
    .avs_waitrequest_o(avs_waitrequest_o), .dqs_oe_o(dqs_oe_o), .dq_o(dq_o),
    .dq_oe_o(dq_oe_o));

// ---- testbench/dbdp_dev_model.sv ----
// Purpose: behavioural memory channel facing the host
// Assumes: direction of each command given by the bench
// Notes:   released strobe reads low, released data inverted
`timescale 1ns/10ps
module dbdp_dev_model #(
    parameter int RD_DELAY = 6,
    parameter bit TOG_PRE  = 1'b0
) (
    input  wire logic        ck_i,
    input  wire logic        cs_i,
    input  wire logic [5:0]  ca_i,
    input  wire logic        rd_i,
    input  wire logic        bl32_i,
    input  wire logic        ext_i,
    input  wire logic        dqs_h_i,
    input  wire logic        dqs_oe_i,
    input  wire logic [7:0]  dq_h_i,
    input  wire logic        dq_oe_i,
    output logic             dqs_o,
    output logic      [7:0]  dq_o,
    output int               ncmd_o,
    output logic      [5:0]  ca_o,
    output int               wcnt_o,
    output logic      [31:0] wword_o
);
    logic       drv;
    logic       dqs_d;
    logic [7:0] dq_d;

    initial begin
        drv = 1'b0;
        dqs_d = 1'b0;
        dq_d = 8'h00;
        ncmd_o = 0;
        ca_o = 6'h00;
        wcnt_o = 0;
        wword_o = 32'h0;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic rd_burst(input logic [5:0] c);
        int n;
        n = bl32_i ? 32 : 16;
        repeat (RD_DELAY - 2) @(posedge ck_i);
        drv = 1'b1;
        repeat (4) begin
            @(ck_i);
            if (TOG_PRE) dqs_d = ~dqs_d;
        end
        for (int k = 0; k < n; k++) begin
            if (k > 0) @(ck_i);
            dqs_d = ~k[0];
            dq_d = {c[3:0], 4'h0} + 8'(k);
        end
        @(ck_i);
        if (ext_i) repeat (2) begin
            dqs_d = ~dqs_d;
            @(ck_i);
        end
        drv = 1'b0;
        dq_d = ~dq_d;
    endtask : rd_burst

    always @(negedge ck_i) begin
        if (cs_i) begin
            ncmd_o = ncmd_o + 1;
            ca_o = ca_i;
            wcnt_o = 0;
            if (rd_i) fork rd_burst(ca_i); join_none
        end
    end

    always @(dqs_h_i) begin
        #1;
        if (dqs_oe_i && dq_oe_i) begin
            if (wcnt_o < 4) wword_o[8*wcnt_o +: 8] = dq_h_i;
            wcnt_o = wcnt_o + 1;
        end
    end

    assign dqs_o = dqs_oe_i ? dqs_h_i : (drv & dqs_d);
    assign dq_o  = dq_oe_i ? dq_h_i : dq_d;
endmodule : dbdp_dev_model

// ---- testbench/test_dram_burst_data_phase.sv ----
// Purpose: self-checking bench for the burst data phase host
// Assumes: default delays and divider
// Notes:   bursts driven through the register port
`timescale 1ns/10ps
`include "dbdp_regs.svh"
module test_dram_burst_data_phase;
    logic        clk_i, rst_i, avs_read, avs_write, avs_wait, ck, cs;
    logic        dqs_h, dqs_oe, dqs_in, dq_oe, rd, bl32, ext;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, wword, q;
    logic [7:0]  dq_h, dq_in;
    logic [5:0]  ca, mca;
    int          ncmd, wcnt, n_mismatch, cmp_count;

    dbdp_host i_dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address),
        .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
        .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_wait), .ck_o(ck), .cs_o(cs),
        .ca_o(ca), .dqs_o(dqs_h), .dqs_oe_o(dqs_oe), .dqs_i(dqs_in), .dq_o(dq_h),
        .dq_oe_o(dq_oe), .dq_i(dq_in));
    dbdp_dev_model i_dev (.ck_i(ck), .cs_i(cs), .ca_i(ca), .rd_i(rd), .bl32_i(bl32),
        .ext_i(ext), .dqs_h_i(dqs_h), .dqs_oe_i(dqs_oe), .dq_h_i(dq_h), .dq_oe_i(dq_oe),
        .dqs_o(dqs_in), .dq_o(dq_in), .ncmd_o(ncmd), .ca_o(mca), .wcnt_o(wcnt),
        .wword_o(wword));
    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_wait !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) begin
            chk("waitrequest", 32'h0, 32'h1);
            finish_test();
        end
    endtask : bus

    task automatic wait_done();
        int n;
        n = 0;
        do begin
            bus(1'b0, `DBDP_OFS_CMD, 32'h0);
            n++;
        end while (q[1:0] !== 2'b10 && n < 300);
        if (n >= 300) begin
            chk("status", 32'h2, q);
            finish_test();
        end
    endtask : wait_done
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    initial begin
        {rst_i, avs_read, avs_write, rd, bl32, ext} = 6'h20;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, `DBDP_OFS_CTRL, 32'h0);
        chk("ctrl reset", `DBDP_CTRL_RESET, q);
        bus(1'b0, `DBDP_OFS_CMD, 32'h0);
        chk("status reset", 32'h0, q);
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped", 32'h0, q);
        for (int i = 0; i < 2; i++) begin
            bl32 <= i[0];
            ext <= i[0];
            rd <= 1'b0;
            bus(1'b1, `DBDP_OFS_CTRL, i[0] ? 32'h70 : 32'h0);
            bus(1'b0, `DBDP_OFS_CTRL, 32'h0);
            chk("ctrl", i[0] ? 32'h70 : 32'h0, q);
            bus(1'b1, `DBDP_OFS_WDATA, 32'h44332211 + i);
            bus(1'b1, `DBDP_OFS_CMD, 32'hc000_06a4);
            wait_done();
            chk("write beats", i[0] ? 32'd32 : 32'd16, wcnt);
            chk("write bytes", 32'h44332211 + i, wword);
            chk("write column", 32'h28, 32'(mca));
            rd <= 1'b1;
            bus(1'b1, `DBDP_OFS_CMD, 32'h8000_0150);
            bus(1'b1, `DBDP_OFS_CMD, 32'hc000_06a4);
            wait_done();
            chk("commands", 32'(2 * i + 2), ncmd);
            chk("read column", 32'h15, 32'(mca));
            bus(1'b0, `DBDP_OFS_RDATA, 32'h0);
            chk("read data", 32'h53525150, q);
        end
        finish_test();
    end
endmodule : test_dram_burst_data_phase
